// File: rtl/acs_map.svh
/*
 Timing constants of the conversion sequencer host, as macros.
 Assumes a system clock of 10 MHz; every count except the end-flag settle count is derived from its time.
*/
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// System clock period
`define ACS_CLK_NS 100
// Least low time of the start pin
`define ACS_T_CNV_LOW_NS 40
// Least acquisition low time
`define ACS_T_ACQ_NS 1400
// Internal reference power-up time
`define ACS_T_REF_UP_NS 45000
// Least times round up to whole cycles
`define ACS_CYC_UP(ns) (((ns) + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_CYC_CNV_LOW `ACS_CYC_UP(`ACS_T_CNV_LOW_NS)
`define ACS_CYC_ACQ `ACS_CYC_UP(`ACS_T_ACQ_NS)
`define ACS_CYC_ACQ_REF `ACS_CYC_UP(`ACS_T_ACQ_NS + `ACS_T_REF_UP_NS)
`define ACS_CYC_REF_GAP `ACS_CYC_UP(`ACS_T_REF_UP_NS)
// Cycles to ignore the end flag after it was re-armed
`define ACS_CYC_EOC_SETTLE 4
// Width of result word and of a command byte
`define ACS_RX_W 16
`define ACS_BYTE_W 8

`endif

// File: rtl/acs_pkg.sv
/*
 Types of the conversion sequencer host: operations, hold choices, command.
 Assumes acs_map.svh for widths.
*/
`include "acs_map.svh"
package acs_pkg;
   typedef enum logic [0:0] {
      ACS_OP_PULSE = 1'b0,
      ACS_OP_FRAME = 1'b1
   } acs_op_t;

   typedef enum logic [1:0] {
      ACS_HOLD_SHORT = 2'h0,
      ACS_HOLD_ACQ = 2'h1,
      ACS_HOLD_REF = 2'h2
   } acs_hold_t;

   typedef struct packed {
      acs_op_t op;
      logic [`ACS_BYTE_W-1:0] tx_byte;
      logic [4:0] nbytes;
      logic [7:0] pulses;
      acs_hold_t hold;
      logic framed;
      logic ref_gap;
      logic eoc_guard;
      logic wait_eoc;
      logic mode11;
   } acs_cmd_t;

   typedef enum logic [5:0] {
      ACS_IDLE = 6'h01,
      ACS_PREW = 6'h02,
      ACS_SHIFT = 6'h04,
      ACS_GAP = 6'h08,
      ACS_CNVLO = 6'h10,
      ACS_EOCW = 6'h20
   } acs_state_t;
endpackage : acs_pkg

// File: rtl/acs_host.sv
/*
 Host controller for a multichannel converter: drives start pin, frames
 serial transfers, waits on end-of-conversion. Assumes the device on the
 pins; MISO and EOC_N arrive asynchronously. SCLK is made here by a divider.
*/
// Function
// - Mode 00: start pin low at least 40 ns then high starts a full scan.
// - Mode 00: no second start pulse before end-of-conversion goes low.
// - Wait for end-of-conversion low before chip select or start goes low; code waits for it before select only with eoc_guard set.
// - Mode 01: start low begins tracking; hold it low at least 1.4 us.
// - Mode 01 with reference mode 00 or 10: add 45 us low time.
// - Mode 01 with temperature: 40 ns low suffices, device times the rest.
// - Mode 01: give exactly the number of start pulses the settings need.
// - Mode 11: 16 clocks after command; chip select gap under 100 us.
// - Mode 11 continuous: zero NOP bytes between conversion bytes.
// - Mode 11 with reference startup: chip select high 45 us after command.
// - Mode 11 temperature: 24 framed zero bytes; result in last two.
// - Never lower chip select before end-of-conversion falls; code holds select high for it only when the command's eoc_guard bit is set.
`include "acs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module acs_host #(
   parameter int SCLK_HALF = 4
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CMD_VALID,
   input wire acs_pkg::acs_cmd_t CMD,
   output logic CMD_READY,
   output logic DONE,
   output logic [`ACS_RX_W-1:0] RESULT,
   output logic CS_N,
   output logic SCLK,
   output logic MOSI,
   output logic CONVERSION_START_N,
   input wire logic MISO,
   input wire logic EOC_N
);
   import acs_pkg::*;

   localparam logic [11:0] CYC_SHORT = 12'(`ACS_CYC_CNV_LOW);
   localparam logic [11:0] CYC_ACQ = 12'(`ACS_CYC_ACQ);
   localparam logic [11:0] CYC_ACQ_REF = 12'(`ACS_CYC_ACQ_REF);
   localparam logic [11:0] CYC_REF_GAP = 12'(`ACS_CYC_REF_GAP);
   localparam logic [11:0] CYC_SETTLE = 12'(`ACS_CYC_EOC_SETTLE);
   localparam logic [11:0] CYC_GAP = 12'(SCLK_HALF);
   localparam logic [7:0] PH_RISE = 8'(SCLK_HALF - 1);
   localparam logic [7:0] PH_FALL = 8'(2 * SCLK_HALF - 1);
   // Extra low half after select falls, so the filtered data line has settled
   localparam logic [7:0] PH_LEAD = 8'h00 - 8'(SCLK_HALF);

   // Three-stage synchronisers, filtered value updates when stages 2 and 3 agree
   logic [1:0] s1;
   logic [1:0] s2;
   logic [1:0] s3;
   logic [1:0] filt;
   logic [1:0] next_filt;
   logic miso_f;
   logic eoc_n_f;

   always_comb begin
      next_filt = filt;
      for (int i = 0; i < 2; i++) begin
         if (s2[i] == s3[i]) begin
            next_filt[i] = s3[i];
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s1 <= 2'h3;
         s2 <= 2'h3;
         s3 <= 2'h3;
         filt <= 2'h3;
      end else begin
         s1 <= {EOC_N, MISO};
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
      end
   end

   assign miso_f = filt[0];
   assign eoc_n_f = filt[1];

   // Sequencer state
   acs_state_t state;
   acs_state_t next_state;
   acs_cmd_t cmd;
   acs_cmd_t next_cmd;
   logic [11:0] timer;
   logic [11:0] next_timer;
   logic [7:0] ph;
   logic [7:0] next_ph;
   logic [2:0] bitn;
   logic [2:0] next_bitn;
   logic [4:0] byten;
   logic [4:0] next_byten;
   logic [7:0] pulsen;
   logic [7:0] next_pulsen;
   logic [`ACS_BYTE_W-1:0] tx;
   logic [`ACS_BYTE_W-1:0] next_tx;
   logic [`ACS_RX_W-1:0] rx;
   logic [`ACS_RX_W-1:0] next_rx;
   logic [`ACS_RX_W-1:0] next_result;
   logic next_ready;
   logic next_done;
   logic next_cs_n;
   logic next_sclk;
   logic next_mosi;
   logic next_cnv_n;
   logic sample_now;

   // Start-pin low time chosen by the command
   function automatic logic [11:0] hold_cycles(input acs_hold_t h);
      logic [11:0] r;
      case (h)
         ACS_HOLD_ACQ: r = CYC_ACQ;
         ACS_HOLD_REF: r = CYC_ACQ_REF;
         default: r = CYC_SHORT;
      endcase
      return r;
   endfunction : hold_cycles

   // Next values of the sequencer
   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_timer = timer;
      next_ph = ph;
      next_bitn = bitn;
      next_byten = byten;
      next_pulsen = pulsen;
      next_tx = tx;
      next_rx = rx;
      next_result = RESULT;
      next_ready = CMD_READY;
      next_done = 1'b0;
      next_cs_n = CS_N;
      next_sclk = SCLK;
      next_mosi = MOSI;
      next_cnv_n = CONVERSION_START_N;
      sample_now = 1'b0;
      case (state)
         ACS_IDLE: begin
            if (CMD_VALID) begin
               next_cmd = CMD;
               next_ready = 1'b0;
               next_pulsen = 8'h00;
               next_byten = 5'h00;
               if (CMD.op == ACS_OP_PULSE) begin
                  next_cnv_n = 1'b0;
                  next_timer = hold_cycles(CMD.hold);
                  next_state = ACS_CNVLO;
               end else begin
                  next_state = ACS_PREW;
               end
            end
         end
         ACS_PREW: begin
            // With the guard set, chip select only falls once the end flag is low
            if (!cmd.eoc_guard || !eoc_n_f) begin
               next_cs_n = 1'b0;
               next_tx = cmd.tx_byte;
               next_mosi = cmd.tx_byte[7];
               next_bitn = 3'h0;
               next_ph = PH_LEAD;
               next_state = ACS_SHIFT;
            end
         end
         ACS_SHIFT: begin
            next_ph = ph + 8'h01;
            if (ph == PH_RISE) begin
               next_sclk = 1'b1;
               sample_now = cmd.mode11;
            end
            if (ph == PH_FALL) begin
               next_sclk = 1'b0;
               sample_now = !cmd.mode11;
               next_ph = 8'h00;
               next_tx = {tx[6:0], 1'b0};
               next_mosi = tx[6];
               next_bitn = bitn + 3'h1;
               if (bitn == 3'h7) begin
                  next_byten = byten + 5'h01;
                  next_tx = '0;
                  next_mosi = 1'b0;
                  if (byten + 5'h01 >= cmd.nbytes) begin
                     next_cs_n = 1'b1;
                     next_timer = CYC_SETTLE;
                     if (cmd.wait_eoc) begin
                        next_state = ACS_EOCW;
                     end else begin
                        next_state = ACS_IDLE;
                        next_done = 1'b1;
                        next_ready = 1'b1;
                     end
                  end else if (cmd.framed) begin
                     next_cs_n = 1'b1;
                     // Long gap after the conversion byte, kept under 100 us
                     next_timer = (byten == 5'h00 && cmd.ref_gap) ?
                        CYC_REF_GAP : CYC_GAP;
                     next_state = ACS_GAP;
                  end
               end
            end
            if (sample_now) begin
               next_rx = {rx[`ACS_RX_W-2:0], miso_f};
            end
            if (next_cs_n && !CS_N) begin
               next_result = next_rx;
            end
         end
         ACS_GAP: begin
            next_timer = timer - 12'h001;
            if (timer <= 12'h001) begin
               next_cs_n = 1'b0;
               next_ph = PH_LEAD;
               next_state = ACS_SHIFT;
            end
         end
         ACS_CNVLO: begin
            next_timer = timer - 12'h001;
            if (timer <= 12'h001) begin
               next_cnv_n = 1'b1;
               next_timer = CYC_SETTLE;
               next_state = ACS_EOCW;
            end
         end
         ACS_EOCW: begin
            // Stale low end flag is ignored while the synchroniser catches up
            if (timer != 12'h000) begin
               next_timer = timer - 12'h001;
            end else if (!eoc_n_f) begin
               next_pulsen = pulsen + 8'h01;
               if (cmd.op == ACS_OP_PULSE && pulsen + 8'h01 < cmd.pulses) begin
                  next_cnv_n = 1'b0;
                  next_timer = hold_cycles(cmd.hold);
                  next_state = ACS_CNVLO;
               end else begin
                  next_done = 1'b1;
                  next_ready = 1'b1;
                  next_state = ACS_IDLE;
               end
            end
         end
         default: begin
            next_state = ACS_IDLE;
            next_ready = 1'b1;
            next_cs_n = 1'b1;
            next_sclk = 1'b0;
            next_cnv_n = 1'b1;
         end
      endcase
   end

   // Registers of the sequencer and its pins
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= ACS_IDLE;
         cmd <= '0;
         timer <= 12'h000;
         ph <= 8'h00;
         bitn <= 3'h0;
         byten <= 5'h00;
         pulsen <= 8'h00;
         tx <= '0;
         rx <= '0;
         RESULT <= '0;
         CMD_READY <= 1'b1;
         DONE <= 1'b0;
         CS_N <= 1'b1;
         SCLK <= 1'b0;
         MOSI <= 1'b0;
         CONVERSION_START_N <= 1'b1;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         timer <= next_timer;
         ph <= next_ph;
         bitn <= next_bitn;
         byten <= next_byten;
         pulsen <= next_pulsen;
         tx <= next_tx;
         rx <= next_rx;
         RESULT <= next_result;
         CMD_READY <= next_ready;
         DONE <= next_done;
         CS_N <= next_cs_n;
         SCLK <= next_sclk;
         MOSI <= next_mosi;
         CONVERSION_START_N <= next_cnv_n;
      end
   end
endmodule : acs_host

`default_nettype wire

// File: tb/acs_host_sva.sv
/* Checker of the sequencer host, watching the top module's ports only.
 Assumes acs_pkg and acs_map.svh are compiled first; bound below. */
`include "acs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_host_sva import acs_pkg::*; #(
   parameter int SCLK_HALF = 4
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CMD_VALID,
   input wire acs_pkg::acs_cmd_t CMD,
   input wire logic CMD_READY,
   input wire logic DONE,
   input wire logic [`ACS_RX_W-1:0] RESULT,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic MOSI,
   input wire logic CONVERSION_START_N,
   input wire logic MISO,
   input wire logic EOC_N
);
   acs_cmd_t lat;
   logic [9:0] lo_cnt;
   logic [7:0] hi_cnt;
   logic [7:0] n_pls;
   logic armed;
   logic rise;
   int need;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_take;
      CMD_VALID && CMD_READY;
   endsequence
   // Start pin release and the low time it needs
   assign rise = CONVERSION_START_N && lo_cnt != 10'h0;
   assign need = (lat.hold == ACS_HOLD_SHORT) ? `ACS_CYC_CNV_LOW :
      (lat.hold == ACS_HOLD_ACQ) ? `ACS_CYC_ACQ : `ACS_CYC_ACQ_REF;
   // Command copy, low and high counts, pulse count, pending flag
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lat <= '0;
         lo_cnt <= '0;
         hi_cnt <= '0;
         n_pls <= '0;
         armed <= 1'b0;
      end else begin
         if (CMD_VALID && CMD_READY) lat <= CMD;
         lo_cnt <= CONVERSION_START_N ? 10'h0 : lo_cnt + 10'h1;
         hi_cnt <= SCLK ? hi_cnt + 8'h1 : 8'h0;
         n_pls <= (CMD_VALID && CMD_READY) ? 8'h0 : n_pls + 8'(rise);
         armed <= rise | (armed & EOC_N);
      end
   end
   chk_take_busy: assert property (s_take |=> !CMD_READY) else $error("ready after take");
   chk_done_once: assert property (DONE |=> !DONE) else $error("done too long");
   chk_done_ready: assert property ($rose(CMD_READY) |-> DONE) else $error("ready without done");
   chk_start_low: assert property ($rose(CONVERSION_START_N) |-> lo_cnt >= need)
      else $error("start low too short");
   chk_one_pulse: assert property ($fell(CONVERSION_START_N) |-> !armed)
      else $error("start before end flag");
   chk_cs_guard: assert property ($fell(CS_N) && lat.eoc_guard |-> !$past(EOC_N))
      else $error("select before end flag");
   chk_sclk_high: assert property ($fell(SCLK) |-> hi_cnt == SCLK_HALF) else $error("clock high");
   chk_sclk_idle: assert property (CS_N |-> !SCLK) else $error("clock outside frame");
   chk_pulse_count: assert property (DONE && lat.op == ACS_OP_PULSE |->
      n_pls == ((lat.pulses == 8'h0) ? 8'h1 : lat.pulses) && !EOC_N) else $error("pulse count");
   chk_result_hold: assert property (!$stable(RESULT) |->
      CS_N && (!$past(CS_N) || !$past(CS_N, 2))) else $error("result moved in frame");
endmodule : acs_host_sva
bind acs_host acs_host_sva #(.SCLK_HALF(SCLK_HALF)) i_sva (.CLK(CLK), .SYS_RST(SYS_RST),
   .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY), .DONE(DONE), .RESULT(RESULT),
   .CS_N(CS_N), .SCLK(SCLK), .MOSI(MOSI), .CONVERSION_START_N(CONVERSION_START_N),
   .MISO(MISO), .EOC_N(EOC_N));
`default_nettype wire

// File: tb/acs_dev.sv
/* Behavioural converter: start pin, end flag, result store, serial port.
 Assumes the host makes the serial clock; mode and averaging set by the bench. */
`timescale 1ns/1ps
`default_nettype none
module acs_dev #(
   parameter logic [15:0] TEMP_WORD = 16'h0190,
   parameter logic [15:0] CHAN_BASE = 16'h0a50,
   parameter logic [15:0] M11_WORD = 16'h0c3a,
   parameter int CONV_NS = 3000,
   parameter int TEMP_NS = 53100
) (
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic MOSI,
   input wire logic CONVERSION_START_N,
   input wire logic mode11,
   input wire logic temp_req,
   input wire logic [3:0] avg,
   output logic MISO,
   output logic EOC_N
);
   logic [15:0] fifo[$];
   logic [15:0] sh = 16'h0;
   logic [7:0] rx = 8'h0;
   logic cmd_seen = 1'b0;
   logic cnv_lo = 1'b0;
   int nb = 0;
   int n_conv = 0;
   int n_res = 0;
   initial EOC_N = 1'b1;
   // Released line shows the inverse of the shift register's top bit
   assign MISO = CS_N ? ~sh[15] : sh[15];
   // Timed conversion, averaged store, then end flag
   task automatic convert;
      #(CONV_NS + (temp_req ? TEMP_NS : 0));
      n_conv++;
      if (n_conv >= avg) begin
         n_conv = 0;
         if (temp_req) fifo.push_back(TEMP_WORD);
         fifo.push_back(CHAN_BASE + 16'(n_res));
         n_res++;
      end
      EOC_N = 1'b0;
   endtask : convert
   // End flag held until select or start falls
   always @(negedge CS_N or negedge CONVERSION_START_N) begin
      EOC_N = 1'b1;
      cnv_lo = !CONVERSION_START_N;
   end
   // Start pin release launches a conversion
   always @(posedge CONVERSION_START_N) if (cnv_lo) convert();
   // Command byte in a frame launches a scan outside mode 11
   always @(posedge CS_N) begin
      if (cmd_seen && !mode11) convert();
      cmd_seen = 1'b0;
   end
   // Frame start outside mode 11 loads the next stored word, MSB first
   always @(negedge CS_N) begin
      nb = 0;
      if (!mode11 && fifo.size() > 0) sh = fifo.pop_front();
   end
   // Output moves on falling clock outside mode 11
   always @(negedge SCLK) if (!mode11) sh = sh << 1;
   // Command capture, first byte of a frame only; mode 11 output on rising clock
   always @(posedge SCLK) begin
      rx = {rx[6:0], MOSI};
      nb++;
      if (mode11) sh = (nb == 8 && rx[7]) ? M11_WORD : sh << 1;
      if (nb == 8 && rx[7]) cmd_seen = 1'b1;
   end
endmodule : acs_dev
`default_nettype wire

// File: tb/acs_host_tb.sv
/* Self-checking bench of the sequencer host against the converter model.
 Assumes acs_pkg, acs_host, acs_dev and the checker are compiled first. */
`include "acs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_host_tb;
   import acs_pkg::*;
   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic CMD_VALID = 1'b0;
   acs_cmd_t CMD = '0;
   logic CMD_READY, DONE, CS_N, SCLK, MOSI, CONVERSION_START_N, MISO, EOC_N;
   logic [`ACS_RX_W-1:0] RESULT;
   logic mode11 = 1'b0;
   logic temp_req = 1'b0;
   logic [3:0] avg = 4'h1;
   int error_cnt = 0;
   int n_compared = 0;
   // Clock and the two instances
   always #50 CLK = ~CLK;
   acs_host #(.SCLK_HALF(4)) i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
      .CMD(CMD), .CMD_READY(CMD_READY), .DONE(DONE), .RESULT(RESULT), .CS_N(CS_N),
      .SCLK(SCLK), .MOSI(MOSI), .CONVERSION_START_N(CONVERSION_START_N), .MISO(MISO),
      .EOC_N(EOC_N));
   acs_dev i_dev (.CS_N(CS_N), .SCLK(SCLK), .MOSI(MOSI), .CONVERSION_START_N(CONVERSION_START_N),
      .mode11(mode11), .temp_req(temp_req), .avg(avg), .MISO(MISO), .EOC_N(EOC_N));
   task automatic stop_test;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Offer one command, wait for its completion pulse
   task automatic run(input acs_op_t op, input logic [7:0] tx, input logic [4:0] nb,
      input logic [7:0] np, input acs_hold_t hd, input logic [4:0] fl);
      int n;
      CMD = acs_cmd_t'({op, tx, nb, np, hd, fl});
      CMD_VALID = 1'b1;
      @(posedge CLK);
      #1 CMD_VALID = 1'b0;
      n = 0;
      while (DONE !== 1'b1 && n < 5000) begin
         @(posedge CLK);
         #1 n++;
      end
      n_compared++;
      if (n >= 5000) begin
         error_cnt++;
         $display("BAD t=%0t done=%h exp=%h", $time, DONE, 1'b1);
      end
   endtask : run
   // Two-byte read, optionally guarded by the end flag
   task automatic rd(input logic g, input logic [15:0] exp);
      run(ACS_OP_FRAME, 8'h00, 5'h02, 8'h00, ACS_HOLD_SHORT, {2'h0, g, 2'h0});
      check(RESULT, exp);
   endtask : rd
   // Watchdog
   initial begin
      #1000000;
      error_cnt++;
      $display("Watchdog expired");
      stop_test;
   end
   // Test sequence
   initial begin
      repeat (6) @(posedge CLK);
      #1 SYS_RST = 1'b0;
      temp_req = 1'b1;
      run(ACS_OP_PULSE, 8'h00, 5'h00, 8'h01, ACS_HOLD_SHORT, 5'h00);
      check({15'h0, EOC_N}, 16'h0);
      rd(1'b1, 16'h0190);
      rd(1'b0, 16'h0a50);
      $display("Scan with temperature done");
      temp_req = 1'b0;
      avg = 4'h3;
      run(ACS_OP_PULSE, 8'h00, 5'h00, 8'h03, ACS_HOLD_ACQ, 5'h00);
      rd(1'b1, 16'h0a51);
      avg = 4'h1;
      run(ACS_OP_PULSE, 8'h00, 5'h00, 8'h00, ACS_HOLD_REF, 5'h00);
      rd(1'b1, 16'h0a52);
      $display("Pulsed conversions done");
      run(ACS_OP_FRAME, 8'h80, 5'h01, 8'h00, ACS_HOLD_SHORT, 5'h02);
      check({15'h0, EOC_N}, 16'h0);
      check({8'h00, i_dev.rx}, 16'h0080);
      rd(1'b1, 16'h0a53);
      $display("Command-started scan done");
      mode11 = 1'b1;
      run(ACS_OP_FRAME, 8'h80, 5'h03, 8'h00, ACS_HOLD_SHORT, 5'h19);
      check(RESULT, 16'h0c3a);
      $display("Serially clocked conversion done");
      stop_test;
   end
endmodule : acs_host_tb
`default_nettype wire
